/* File: core/mipu_cfg.svh */
// constants of the interrupt priority unit: offsets, fields, vectors, reset values
`ifndef MIPU_CFG_SVH
`define MIPU_CFG_SVH
`define MIPU_ADDR_W        8
`define MIPU_OFS_OPTION    8'hC8
`define MIPU_OFS_STATUS    8'hCC
`define MIPU_OFS_EVFLAG    8'hD0
`define MIPU_OPT_LES       6
`define MIPU_OPT_ESB       5
`define MIPU_OPT_GEN       4
`define MIPU_OPT_RESET     8'h00
`define MIPU_VEC_SRC0      12'hFFC
`define MIPU_VEC_SRC1      12'hFF6
`define MIPU_VEC_SRC2      12'hFF4
`define MIPU_VEC_SRC3      12'hFF2
`define MIPU_VEC_SRC4      12'hFF0
`define MIPU_ANOM_CYC      2'h3
`define MIPU_RESP_OKAY     2'h0
`define MIPU_RESP_SLVERR   2'h2
`endif

/* File: core/mipu_pkg.sv */
// types shared by the interrupt priority unit
package mipu_pkg;
    typedef enum logic [1:0] {MD_NORMAL, MD_MASK, MD_NMI} mipu_mode_e;
    typedef struct packed {
        logic instr_end;
        logic return_from_service_instr;
        logic opt_clr_instr;
        logic flag_we;
        logic carry;
        logic zero;
    } mipu_core_req_s;
    typedef struct packed {
        logic       take;
        logic       pop;
        logic [11:0] vector;
        mipu_mode_e mode;
        mipu_mode_e flag_set;
        logic       carry;
        logic       zero;
        logic       wake;
    } mipu_core_rsp_s;
endpackage

/* File: core/mipu_top.sv */
// interrupt priority unit: request capture, arbitration, flag sets, axi4-lite option port
`timescale 1ns/1ps
`default_nettype none
`include "mipu_cfg.svh"

module mipu_top #(
    parameter int N0 = 1,
    parameter int N1 = 2,
    parameter int N2 = 2,
    parameter int N3 = 5,
    parameter int N4 = 4
) (
    input  wire logic                   i_clk_sys,
    input  wire logic                   i_srst,
    input  wire logic [N0-1:0]          i_src0_pin_n,
    input  wire logic [N1-1:0]          i_src1_pin_n,
    input  wire logic [N2-1:0]          i_src2_pin,
    input  wire logic [N3-1:0]          i_src3_event,
    input  wire logic [N4-1:0]          i_src4_event,
    input  wire logic                   i_sleep,
    input  wire mipu_pkg::mipu_core_req_s i_core,
    output var  mipu_pkg::mipu_core_rsp_s o_core,
    input  wire logic [`MIPU_ADDR_W-1:0] i_awaddr,
    input  wire logic                   i_awvalid,
    output logic                        o_awready,
    input  wire logic [31:0]            i_wdata,
    input  wire logic [3:0]             i_wstrb,
    input  wire logic                   i_wvalid,
    output logic                        o_wready,
    output logic [1:0]                  o_bresp,
    output logic                        o_bvalid,
    input  wire logic                   i_bready,
    input  wire logic [`MIPU_ADDR_W-1:0] i_araddr,
    input  wire logic                   i_arvalid,
    output logic                        o_arready,
    output logic [31:0]                 o_rdata,
    output logic [1:0]                  o_rresp,
    output logic                        o_rvalid,
    input  wire logic                   i_rready
);
    localparam int NPIN = N0 + N1 + N2;
    localparam int NEV  = NPIN + N3 + N4;

    logic [NPIN-1:0]          pin_s1;
    logic [NPIN-1:0]          pin_s2;
    logic [NPIN-1:0]          pin_q;
    logic [7:0]               option;
    logic                     level_edge_select;
    logic                     edge_polarity_select;
    logic                     gen;
    logic                     nmi_lat;
    logic                     lat1;
    logic                     lat2;
    logic [NEV-1:0]           ev_flag;
    logic [NEV-1:0]           ev_hit;
    logic [NEV-1:0]           ev_clr;
    logic                     line0_n;
    logic                     line1_n;
    logic                     line0_q;
    logic                     line1_q;
    logic [N2-1:0]            pin2;
    logic [N2-1:0]            pin2_q;
    logic [N2-1:0]            edge2;
    logic [4:1]               req;
    logic [4:1]               pick;
    mipu_pkg::mipu_mode_e     mode;
    mipu_pkg::mipu_mode_e     fsel;
    mipu_pkg::mipu_mode_e     prev_mode;
    mipu_pkg::mipu_mode_e     prev_fsel;
    mipu_pkg::mipu_mode_e     cur_mode;
    mipu_pkg::mipu_mode_e     cur_fsel;
    mipu_pkg::mipu_mode_e     next_mode;
    mipu_pkg::mipu_mode_e     next_fsel;
    logic                     take_nmi;
    logic                     take_mask;
    logic [11:0]              next_vector;
    logic [1:0]               anom_cnt;
    logic                     anom_arm;
    logic [1:0]               fl [3];
    logic [1:0]               next_fl;
    logic                     aw_got;
    logic                     w_got;
    logic [`MIPU_ADDR_W-1:0]  aw_q;
    logic [31:0]              w_q;
    logic [3:0]               ws_q;
    logic                     do_wr;
    logic [31:0]              ws_mask;

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and combined request lines

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            pin_s1 <= '1;
            pin_s2 <= '1;
            pin_q  <= '1;
        end else begin
            pin_s1 <= {i_src2_pin, i_src1_pin_n, i_src0_pin_n};
            pin_s2 <= pin_s1;
            pin_q  <= pin_s2;
        end
    end

    assign level_edge_select     = option[`MIPU_OPT_LES];
    assign edge_polarity_select     = option[`MIPU_OPT_ESB];
    assign gen     = option[`MIPU_OPT_GEN];
    // low-active pins pull the shared line low, like a wired connection
    assign line0_n = &pin_s2[N0-1:0];
    assign line1_n = &pin_s2[N0+N1-1:N0];
    assign line0_q = &pin_q[N0-1:0];
    assign line1_q = &pin_q[N0+N1-1:N0];
    assign pin2    = pin_s2[NPIN-1:N0+N1];
    assign pin2_q  = pin_q[NPIN-1:N0+N1];
    assign edge2   = edge_polarity_select ? (pin2 & ~pin2_q) : (~pin2 & pin2_q);

    ////////////////////////////////////////////////////////////////////////////////
    // per-event sticky flags, set wins over software clear

    assign ev_hit = {i_src4_event, i_src3_event, edge2,
                     ~pin_s2[N0+N1-1:0]};

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            ev_flag <= '0;
        end else begin
            ev_flag <= (ev_flag & ~ev_clr) | ev_hit;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // request latches and arbitration

    // level sources are read live at the sampling point, never stored
    assign req[1] = level_edge_select ? ~line1_n : lat1;
    assign req[2] = lat2;
    assign req[3] = |i_src3_event;
    assign req[4] = |i_src4_event;
    assign pick[1] = req[1];
    assign pick[2] = req[2] & ~req[1];
    assign pick[3] = req[3] & ~|req[2:1];
    assign pick[4] = req[4] & ~|req[3:1];

    always_comb begin
        cur_mode = mode;
        cur_fsel = fsel;
        if (i_core.return_from_service_instr) begin
            cur_mode = (mode == mipu_pkg::MD_NMI) ? prev_mode : mipu_pkg::MD_NORMAL;
            cur_fsel = (mode == mipu_pkg::MD_NMI) ? prev_fsel : mipu_pkg::MD_NORMAL;
        end
    end

    assign take_nmi  = i_core.instr_end & nmi_lat & (cur_mode != mipu_pkg::MD_NMI);
    assign take_mask = i_core.instr_end & ~take_nmi & (cur_mode == mipu_pkg::MD_NORMAL)
                       & |req & (gen | anom_arm);

    always_comb begin
        next_mode   = cur_mode;
        next_fsel   = cur_fsel;
        next_vector = o_core.vector;
        if (take_nmi) begin
            next_mode   = mipu_pkg::MD_NMI;
            next_fsel   = mipu_pkg::MD_NMI;
            next_vector = `MIPU_VEC_SRC0;
        end else if (take_mask) begin
            next_mode = mipu_pkg::MD_MASK;
            // the anomaly keeps the normal pair live inside the routine
            next_fsel = anom_arm ? cur_fsel : mipu_pkg::MD_MASK;
            unique case (1'b1)
                pick[1]: next_vector = `MIPU_VEC_SRC1;
                pick[2]: next_vector = `MIPU_VEC_SRC2;
                pick[3]: next_vector = `MIPU_VEC_SRC3;
                default: next_vector = `MIPU_VEC_SRC4;
            endcase
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            nmi_lat <= 1'b0;
            lat1    <= 1'b0;
            lat2    <= 1'b0;
        end else begin
            // an edge in the clearing cycle is kept; repeat edges fold into one
            nmi_lat <= (nmi_lat & ~take_nmi) | (~line0_n & line0_q);
            lat1 <= (lat1 & ~(take_mask & pick[1]))
                    | (~level_edge_select & ~line1_n & line1_q);
            lat2 <= (lat2 & ~(take_mask & pick[2])) | |edge2;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            mode      <= mipu_pkg::MD_NMI;
            fsel      <= mipu_pkg::MD_NMI;
            prev_mode <= mipu_pkg::MD_NORMAL;
            prev_fsel <= mipu_pkg::MD_NORMAL;
        end else begin
            mode <= next_mode;
            fsel <= next_fsel;
            if (take_nmi) begin
                prev_mode <= cur_mode;
                prev_fsel <= cur_fsel;
            end
        end
    end

    // counts cycles of the option-clearing immediate write
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            anom_cnt <= '0;
            anom_arm <= 1'b0;
        end else begin
            if (!i_core.opt_clr_instr || i_core.instr_end) begin
                anom_cnt <= '0;
            end else if (anom_cnt != `MIPU_ANOM_CYC) begin
                anom_cnt <= anom_cnt + 2'h1;
            end
            if (i_core.instr_end) begin
                anom_arm <= 1'b0;
            end else if (i_core.opt_clr_instr && anom_cnt < `MIPU_ANOM_CYC
                         && mode == mipu_pkg::MD_NORMAL && gen && |req) begin
                anom_arm <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // carry/zero flag sets

    always_comb begin
        next_fl = fl[next_fsel];
        if (i_core.flag_we) begin
            next_fl = {i_core.carry, i_core.zero};
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            fl[0] <= '0;
            fl[1] <= '0;
            fl[2] <= '0;
        end else if (i_core.flag_we) begin
            fl[next_fsel] <= next_fl;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // core-side outputs

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_core          <= '0;
            o_core.mode     <= mipu_pkg::MD_NMI;
            o_core.flag_set <= mipu_pkg::MD_NMI;
        end else begin
            o_core.take     <= take_nmi | take_mask;
            o_core.pop      <= i_core.return_from_service_instr;
            o_core.vector   <= next_vector;
            o_core.mode     <= next_mode;
            o_core.flag_set <= next_fsel;
            o_core.carry    <= next_fl[1];
            o_core.zero     <= next_fl[0];
            o_core.wake     <= i_sleep & gen & (nmi_lat | |req);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // axi4-lite slave

    assign do_wr  = aw_got & w_got & ~o_bvalid;
    // byte strobes gate the clear; only the low NEV bits of the word are flags
    assign ws_mask = {{8{ws_q[3]}}, {8{ws_q[2]}}, {8{ws_q[1]}}, {8{ws_q[0]}}};
    assign ev_clr  = (do_wr && aw_q[`MIPU_ADDR_W-1:2] == `MIPU_OFS_EVFLAG >> 2)
                     ? (w_q[NEV-1:0] & ws_mask[NEV-1:0]) : '0;

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_awready <= 1'b0;
            aw_got    <= 1'b0;
            aw_q      <= '0;
        end else if (o_awready && i_awvalid) begin
            o_awready <= 1'b0;
            aw_got    <= 1'b1;
            aw_q      <= i_awaddr;
        end else if (do_wr) begin
            aw_got <= 1'b0;
        end else if (!aw_got) begin
            o_awready <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_wready <= 1'b0;
            w_got    <= 1'b0;
            w_q      <= '0;
            ws_q     <= '0;
        end else if (o_wready && i_wvalid) begin
            o_wready <= 1'b0;
            w_got    <= 1'b1;
            w_q      <= i_wdata;
            ws_q     <= i_wstrb;
        end else if (do_wr) begin
            w_got <= 1'b0;
        end else if (!w_got) begin
            o_wready <= 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            option   <= `MIPU_OPT_RESET;
            o_bvalid <= 1'b0;
            o_bresp  <= `MIPU_RESP_OKAY;
        end else if (do_wr) begin
            o_bvalid <= 1'b1;
            o_bresp  <= `MIPU_RESP_OKAY;
            unique case (aw_q[`MIPU_ADDR_W-1:2])
                `MIPU_OFS_OPTION >> 2: begin
                    if (ws_q[0]) begin
                        option <= w_q[7:0] & 8'h70;
                    end
                end
                `MIPU_OFS_EVFLAG >> 2: ;
                default: o_bresp <= `MIPU_RESP_SLVERR;
            endcase
        end else if (o_bvalid && i_bready) begin
            o_bvalid <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= `MIPU_RESP_OKAY;
        end else if (o_arready && i_arvalid) begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= '0;
            o_rresp   <= `MIPU_RESP_OKAY;
            unique case (i_araddr[`MIPU_ADDR_W-1:2])
                // option register is write-only and reads as zero
                `MIPU_OFS_OPTION >> 2: o_rdata <= '0;
                `MIPU_OFS_STATUS >> 2: begin
                    o_rdata <= {16'h0000, fsel, mode, nmi_lat, lat1, lat2,
                                anom_arm, req, option[7:4]};
                end
                `MIPU_OFS_EVFLAG >> 2: o_rdata <= 32'(ev_flag);
                default: o_rresp <= `MIPU_RESP_SLVERR;
            endcase
        end else if (o_rvalid && i_rready) begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end else if (!o_rvalid) begin
            o_arready <= 1'b1;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/mipu_seq_model.sv */
// core sequencer model: instruction boundaries, return and flag writes
`timescale 1ns/1ps
`default_nettype none
module mipu_seq_model (
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_srst,
    input  wire logic                  i_return_from_service_instr_cmd,
    input  wire logic                  i_flag_cmd,
    input  wire logic [1:0]            i_flags,
    input  wire logic                  i_optclr_cmd,
    output var  mipu_pkg::mipu_core_req_s o_req
);
    logic [1:0] cnt;
    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge i_clk_sys) begin
        if (i_srst) begin
            cnt   <= 2'h0;
            o_req <= '0;
        end else begin
            cnt                 <= cnt + 2'h1;
            o_req.instr_end     <= (cnt == 2'h3);
            // return only at a boundary, as a real instruction would end
            o_req.return_from_service_instr          <= (cnt == 2'h3) && i_return_from_service_instr_cmd;
            o_req.flag_we       <= (cnt == 2'h3) && i_flag_cmd;
            o_req.carry         <= i_flags[1];
            o_req.zero          <= i_flags[0];
            o_req.opt_clr_instr <= i_optclr_cmd;
        end
    end
endmodule
`default_nettype wire

/* File: testbench/mipu_top_checker.sv */
// assertions on the core-side ports of the interrupt priority unit
`timescale 1ns/1ps
`default_nettype none
`include "mipu_cfg.svh"
module mipu_top_checker (
    input wire logic                     i_clk_sys,
    input wire logic                     i_srst,
    input wire logic                     i_sleep,
    input wire mipu_pkg::mipu_core_req_s i_core,
    input wire mipu_pkg::mipu_core_rsp_s o_core
);
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (i_srst);
    ////////////////////////////////////////////////////////////////////////////////
    property p_take_at_end;
        o_core.take |-> $past(i_core.instr_end);
    endproperty
    a_take_at_end: assert property (p_take_at_end)
        else $error("take away from an instruction end");
    property p_reset_nmi;
        $fell(i_srst) |-> o_core.mode == mipu_pkg::MD_NMI && o_core.flag_set == mipu_pkg::MD_NMI;
    endproperty
    a_reset_nmi: assert property (p_reset_nmi)
        else $error("not in nmi mode after reset");
    property p_no_preempt;
        o_core.mode == mipu_pkg::MD_MASK && !i_core.return_from_service_instr |=>
            !o_core.take || o_core.mode == mipu_pkg::MD_NMI;
    endproperty
    a_no_preempt: assert property (p_no_preempt)
        else $error("maskable routine pre-empted by maskable");
    property p_pop;
        i_core.return_from_service_instr |=> o_core.pop;
    endproperty
    a_pop: assert property (p_pop)
        else $error("no pop after return");
    property p_return_from_service_instr_mode;
        i_core.return_from_service_instr && o_core.mode == mipu_pkg::MD_MASK |=>
            o_core.mode != mipu_pkg::MD_MASK || o_core.take;
    endproperty
    a_return_from_service_instr_mode: assert property (p_return_from_service_instr_mode)
        else $error("mode kept after return");
    property p_wake;
        o_core.wake |-> $past(i_sleep);
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake while not sleeping");
    property p_mask_vec;
        o_core.take && o_core.mode == mipu_pkg::MD_MASK |-> o_core.vector inside
            {`MIPU_VEC_SRC1, `MIPU_VEC_SRC2, `MIPU_VEC_SRC3, `MIPU_VEC_SRC4};
    endproperty
    a_mask_vec: assert property (p_mask_vec)
        else $error("bad maskable vector");
    property p_nmi_vec;
        o_core.take && o_core.mode == mipu_pkg::MD_NMI |->
            o_core.vector == `MIPU_VEC_SRC0 && o_core.flag_set == mipu_pkg::MD_NMI;
    endproperty
    a_nmi_vec: assert property (p_nmi_vec)
        else $error("bad nmi vector or flag set");
endmodule
bind mipu_top mipu_top_checker u_chk (.i_clk_sys(i_clk_sys), .i_srst(i_srst),
    .i_sleep(i_sleep), .i_core(i_core), .o_core(o_core));
`default_nettype wire

/* File: testbench/mipu_top_tb.sv */
// self-checking bench of the interrupt priority unit
`timescale 1ns/1ps
`default_nettype none
`include "mipu_cfg.svh"
module mipu_top_tb;
    logic        clk, srst, sleep, awv, wv, brdy, arv, rrdy, awr, wr, bv, arr, rv, rcmd, fcmd;
    logic        ocmd;
    logic [0:0]  s0;
    logic [1:0]  s1, s2, bresp, rresp;
    logic [4:0]  s3;
    logic [3:0]  s4;
    logic [7:0]  awa, ara;
    logic [31:0] wd, rd;
    logic [13:0] tq[$];
    int          err_count, compares, cyc;
    mipu_pkg::mipu_core_req_s creq;
    mipu_pkg::mipu_core_rsp_s crsp;
    mipu_top dut (.i_clk_sys(clk), .i_srst(srst), .i_src0_pin_n(s0), .i_src1_pin_n(s1),
        .i_src2_pin(s2), .i_src3_event(s3), .i_src4_event(s4), .i_sleep(sleep), .i_core(creq),
        .o_core(crsp), .i_awaddr(awa), .i_awvalid(awv), .o_awready(awr), .i_wdata(wd),
        .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wr), .o_bresp(bresp), .o_bvalid(bv),
        .i_bready(brdy), .i_araddr(ara), .i_arvalid(arv), .o_arready(arr), .o_rdata(rd),
        .o_rresp(rresp), .o_rvalid(rv), .i_rready(rrdy));
    mipu_seq_model u_seq (.i_clk_sys(clk), .i_srst(srst), .i_return_from_service_instr_cmd(rcmd),
        .i_flag_cmd(fcmd), .i_flags(2'h3), .i_optclr_cmd(ocmd), .o_req(creq));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    always @(negedge clk) begin
        if (crsp.take === 1'b1) tq.push_back({crsp.mode, crsp.vector});
    end
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            test_done();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic test_done();
        $display("compares %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    function automatic logic [11:0] exp_vec(input logic [3:0] p);
        if (p[0]) return `MIPU_VEC_SRC1;
        if (p[1]) return `MIPU_VEC_SRC2;
        if (p[2]) return `MIPU_VEC_SRC3;
        return `MIPU_VEC_SRC4;
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awa <= a;
        wd <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        brdy <= 1'b1;
        // ends when bv is seen high; the bench timeout is the only other way out
        do begin
            @(posedge clk);
            if (awr === 1'b1 && awv) awv <= 1'b0;
            if (wr === 1'b1 && wv) wv <= 1'b0;
        end while (bv !== 1'b1);
        brdy <= 1'b0;
        check("bresp", {29'h0, bv, bresp}, {29'h0, 1'b1, er});
    endtask
    task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rrdy <= 1'b1;
        do begin
            @(posedge clk);
            if (arr === 1'b1 && arv) arv <= 1'b0;
        end while (rv !== 1'b1);
        rrdy <= 1'b0;
        check("rresp", {29'h0, rv, rresp}, {29'h0, 1'b1, er});
        check("rdata", rd, ed);
    endtask
    task automatic serve(input logic [11:0] ev, input mipu_pkg::mipu_mode_e em);
        int n;
        n = 0;
        while (tq.size() == 0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        check("take", {18'h0, tq.size() > 0 ? tq.pop_front() : 14'h3FFF}, {18'h0, em, ev});
    endtask
    task automatic no_take(input int n);
        tick(n);
        check("no_take", tq.size(), 32'h0);
    endtask
    task automatic do_return_from_service_instr();
        int n;
        n = 0;
        @(posedge clk);
        rcmd <= 1'b1;
        while (crsp.pop !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        rcmd <= 1'b0;
        check("pop", {31'h0, crsp.pop}, 32'h1);
    endtask
    task automatic pulse_nmi();
        s0 <= 1'b0;
        tick(4);
        s0 <= 1'b1;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [31:0] r;
        logic [3:0]  p;
        logic [11:0] ev;
        {cyc, err_count, compares} = '0;
        {srst, sleep, awv, wv, brdy, arv, rrdy, rcmd, fcmd, ocmd} = 10'h200;
        {s0, s1, s2, s3, s4, awa, ara, wd} = {5'h1F, 57'h0};
        r = $urandom(32'h74d9a334);
        repeat (8) @(posedge clk);
        srst <= 1'b0;
        check("mode", crsp.mode, mipu_pkg::MD_NMI);
        axi_rd(`MIPU_OFS_STATUS, 32'hA000, `MIPU_RESP_OKAY);
        axi_rd(`MIPU_OFS_OPTION, 32'h0, `MIPU_RESP_OKAY);
        axi_rd(8'h04, 32'h0, `MIPU_RESP_SLVERR);
        axi_wr(8'h04, 32'h10, `MIPU_RESP_SLVERR);
        s3 <= 5'h04;
        tick(1);
        s3 <= 5'h00;
        axi_rd(`MIPU_OFS_EVFLAG, 32'h80, `MIPU_RESP_OKAY);
        axi_wr(`MIPU_OFS_EVFLAG, 32'h80, `MIPU_RESP_OKAY);
        axi_rd(`MIPU_OFS_EVFLAG, 32'h0, `MIPU_RESP_OKAY);
        do_return_from_service_instr();
        check("mode", crsp.mode, mipu_pkg::MD_NORMAL);
        fcmd <= 1'b1;
        tick(6);
        fcmd <= 1'b0;
        tick(2);
        check("flags", {crsp.flag_set, crsp.carry, crsp.zero}, 32'h3);
        $display("test reset and flags done");
        axi_wr(`MIPU_OFS_OPTION, 32'h10, `MIPU_RESP_OKAY);
        for (int t = 0; t < 12; t++) begin
            r = $urandom();
            p = (r[3:0] == 4'h0) ? 4'h4 : r[3:0];
            pulse_nmi();
            serve(`MIPU_VEC_SRC0, mipu_pkg::MD_NMI);
            // levels held until their take is seen
            s3 <= p[2] ? 5'h01 << r[5:4] : 5'h00;
            s4 <= p[3] ? 4'h1 << r[7:6] : 4'h0;
            s1 <= p[0] ? 2'h0 : 2'h3;
            s2 <= p[1] ? 2'h2 : 2'h3;
            tick(2);
            s2 <= 2'h3;
            tick(2);
            s2 <= p[1] ? 2'h2 : 2'h3;
            tick(2);
            s1 <= 2'h3;
            s2 <= 2'h3;
            no_take(12);
            while (p != 4'h0) begin
                ev = exp_vec(p);
                do_return_from_service_instr();
                serve(ev, mipu_pkg::MD_MASK);
                check("mflags", {crsp.flag_set, crsp.carry, crsp.zero}, 32'h4);
                if (ev == `MIPU_VEC_SRC3) s3 <= 5'h00;
                if (ev == `MIPU_VEC_SRC4) s4 <= 4'h0;
                p = p & (p - 4'h1);
                if (r[8]) begin
                    pulse_nmi();
                    serve(`MIPU_VEC_SRC0, mipu_pkg::MD_NMI);
                    do_return_from_service_instr();
                    check("mode", crsp.mode, mipu_pkg::MD_MASK);
                end
            end
            do_return_from_service_instr();
            no_take(8);
            check("nflags", {crsp.flag_set, crsp.carry, crsp.zero}, 32'h3);
        end
        $display("test priority done");
        axi_wr(`MIPU_OFS_OPTION, 32'h0, `MIPU_RESP_OKAY);
        sleep <= 1'b1;
        s4 <= 4'h8;
        no_take(12);
        check("wake", {31'h0, crsp.wake}, 32'h0);
        pulse_nmi();
        serve(`MIPU_VEC_SRC0, mipu_pkg::MD_NMI);
        do_return_from_service_instr();
        axi_wr(`MIPU_OFS_OPTION, 32'h10, `MIPU_RESP_OKAY);
        serve(`MIPU_VEC_SRC4, mipu_pkg::MD_MASK);
        check("wake", {31'h0, crsp.wake}, 32'h1);
        s4 <= 4'h0;
        sleep <= 1'b0;
        do_return_from_service_instr();
        $display("test enable done");
        axi_wr(`MIPU_OFS_OPTION, 32'h50, `MIPU_RESP_OKAY);
        s1 <= 2'h0;
        serve(`MIPU_VEC_SRC1, mipu_pkg::MD_MASK);
        do_return_from_service_instr();
        serve(`MIPU_VEC_SRC1, mipu_pkg::MD_MASK);
        s1 <= 2'h3;
        do_return_from_service_instr();
        no_take(8);
        axi_wr(`MIPU_OFS_OPTION, 32'h30, `MIPU_RESP_OKAY);
        s2 <= 2'h1;
        no_take(10);
        s2 <= 2'h3;
        serve(`MIPU_VEC_SRC2, mipu_pkg::MD_MASK);
        do_return_from_service_instr();
        $display("test modes done");
        // request raised at the start of the option-clearing write
        @(posedge clk iff creq.instr_end === 1'b1);
        ocmd <= 1'b1;
        s4 <= 4'h8;
        serve(`MIPU_VEC_SRC4, mipu_pkg::MD_MASK);
        check("aflags", crsp.flag_set, mipu_pkg::MD_NORMAL);
        ocmd <= 1'b0;
        s4 <= 4'h0;
        do_return_from_service_instr();
        check("mode", crsp.mode, mipu_pkg::MD_NORMAL);
        $display("test anomaly done");
        test_done();
    end
endmodule
`default_nettype wire
